// *** common/qr_seq_pkg.sv ***
package qr_seq_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ          = 250;
  localparam int RING_SHORT_NS    = 3000;
  localparam int RING_LONG_NS     = 30000;
  localparam int BURST_ARM_NS     = 12000;
  localparam int RESTART_NS       = 50000;
  localparam int COUNT_MS         = 50;
  localparam int SOFT_START_MS    = 24;
  localparam int RING_SHORT_CYC   = RING_SHORT_NS * CLK_MHZ / 1000;
  localparam int RING_LONG_CYC    = RING_LONG_NS * CLK_MHZ / 1000;
  localparam int BURST_ARM_CYC    = BURST_ARM_NS * CLK_MHZ / 1000;
  localparam int RESTART_CYC      = RESTART_NS * CLK_MHZ / 1000;
  localparam int COUNT_CYC        = COUNT_MS * CLK_MHZ * 1000;
  localparam int SOFT_START_CYC   = SOFT_START_MS * CLK_MHZ * 1000;

  // ---------------------------------------------------------------
  // Skip counter
  // ---------------------------------------------------------------
  localparam int          SKIP_W     = 4;
  localparam logic [3:0]  SKIP_RESET = 4'h1;
  localparam logic [3:0]  SKIP_MAX   = 4'hF;
  localparam logic [3:0]  SKIP_MIN   = 4'h0;

  // Comparator results from the analog front end
  typedef struct packed {
    logic pcs_ge_fb;      // Current simulation reached feedback level
    logic zc_above_50m;   // Zero-cross input above 50 mV
    logic zc_above_1v;
    logic zc_above_4v4;
    logic zc_above_5v;
    logic fb_below_2v;
    logic fb_below_3v5;
    logic fb_above_4v4;
    logic fb_above_4v8;
    logic pcs_below_100u; // Off-time current into sim pin too low
    logic fault_trip;
  } cmp_s;

  // Supply comparators
  typedef struct packed {
    logic above_on;       // Supply at turn-on level
    logic below_off_norm; // Supply below 9 V turn-off level
    logic below_off_burst;// Supply below 14.5 V raised turn-off level
    logic above_ovp;      // Supply overvoltage level
    logic below_on_hys;   // Below turn-on level minus burst hysteresis
  } sup_s;

  typedef enum logic [1:0] {
    ST_STARTUP = 2'b00,
    ST_SOFT    = 2'b01,
    ST_RUN     = 2'b11
  } mode_e;

endpackage : qr_seq_pkg

// *** rtl/quasiresonant_gate_sequencer.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Current sim reaching feedback turns gate off and starts ringing timer.
// - No turn-on during suppression: 3 us above 1 V, 30 us below.
// - Feedback discharge sink on while zero-cross input above 5 V.
// - Above 4.4 V sets flag; below 50 mV then opens charging resistor.
// - Charging resistor reconnects on each gate falling edge.
// - Gate turns on when crossings counted reach or exceed the 4-bit skip count.
// - Feedback below 3.5 V counts skip up per 50 ms; mid range holds.
// - Feedback above 4.4 V counts skip down per 50 ms trigger.
// - Feedback above 4.8 V loads skip counter with one immediately.
// - Two range flags captured; 50 ms trigger applies then clears them.
// - Burst comparator ignored until 12 us after soft start begins.
// - Burst: feedback below 2 V forces gate low, raises off level.
// - Supply at off level enters start-up; turn-on restarts, normal level.
// - Restart pulse every 50 us turns gate on when input low and gate low.
// - Restart pulse suppressed while zero-cross input above 50 mV.
// - Overvoltage latch disables gate, clears when supply falls below hysteresis.
// - Fault comparator latch disables gate, clears the same way.
// - Off-time sim pin current below 100 uA latches gate off.
// - Each falling 50 mV crossing counts; gate low while input above 50 mV.
// - Soft start ends 24 ms after switch-on, soft-start sink turns off.
// - Start-up mode holds gate low with reference off.
module quasiresonant_gate_sequencer #(
  parameter int COUNT_PERIOD = qr_seq_pkg::COUNT_CYC,
  parameter int SOFT_PERIOD  = qr_seq_pkg::SOFT_START_CYC
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Comparator inputs
  input  wire qr_seq_pkg::cmp_s  cmp,
  input  wire qr_seq_pkg::sup_s  sup,
  // Power switch and analog controls
  output logic                   gate_drive_r,
  output logic                   fb_sink_en_r,
  output logic                   fb_res_en_r,
  output logic                   soft_sink_en_r,
  output logic                   ref_en_r,
  output logic                   burst_off_sel_r,
  // Status
  output logic [3:0]             skip_count_r,
  output logic                   ovp_latch_r,
  output logic                   fault_latch_r,
  output logic                   uv_latch_r
);
  import qr_seq_pkg::*;

  mode_e       mode_r;
  logic [31:0] soft_cnt_r;
  logic [31:0] period_cnt_r;
  logic        trig;
  logic [15:0] ring_cnt_r;
  logic [15:0] rst_cnt_r;
  logic        zc_prev_r;
  logic        res_flag_r;
  logic        burst_arm_r;
  logic [3:0]  cross_cnt_r;
  logic        up_flag_r;
  logic        dn_flag_r;
  logic        zc_fall;
  logic        turn_off;
  logic        turn_on;
  logic        gate_block;
  logic        restart;

  // ---------------------------------------------------------------
  // Supply mode sequencing
  // ---------------------------------------------------------------
  // Start-up, soft start and run; burst re-enters start-up
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_r     <= ST_STARTUP;
      soft_cnt_r <= '0;
    end else if ((burst_off_sel_r ? sup.below_off_burst : sup.below_off_norm)) begin
      mode_r     <= ST_STARTUP;
      soft_cnt_r <= '0;
    end else begin
      case (mode_r)
        ST_STARTUP: begin
          if (sup.above_on) begin
            mode_r <= ST_SOFT;
          end
        end
        ST_SOFT: begin
          soft_cnt_r <= soft_cnt_r + 32'd1;
          if (soft_cnt_r >= 32'(SOFT_PERIOD - 1)) begin
            mode_r <= ST_RUN;
          end
        end
        default: ;
      endcase
    end
  end

  // Reference and soft-start sink follow the mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ref_en_r       <= 1'b0;
      soft_sink_en_r <= 1'b0;
      burst_arm_r    <= 1'b0;
    end else begin
      ref_en_r       <= (mode_r != ST_STARTUP);
      soft_sink_en_r <= (mode_r == ST_SOFT);
      burst_arm_r    <= (mode_r == ST_RUN) ||
                        (mode_r == ST_SOFT && soft_cnt_r >= 32'(BURST_ARM_CYC));
    end
  end

  // Raised off level held until a fresh turn-on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      burst_off_sel_r <= 1'b0;
    end else if (burst_arm_r && cmp.fb_below_2v) begin
      burst_off_sel_r <= 1'b1;
    end else if (mode_r == ST_STARTUP && sup.above_on) begin
      burst_off_sel_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Protection latches
  // ---------------------------------------------------------------
  // Set wins over clear so a trip is never lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovp_latch_r   <= 1'b0;
      fault_latch_r <= 1'b0;
      uv_latch_r    <= 1'b0;
    end else begin
      if (sup.above_ovp) ovp_latch_r <= 1'b1;
      else if (sup.below_on_hys) ovp_latch_r <= 1'b0;
      if (cmp.fault_trip) fault_latch_r <= 1'b1;
      else if (sup.below_on_hys) fault_latch_r <= 1'b0;
      // Undervoltage also released by the same supply fall
      if (!gate_drive_r && cmp.pcs_below_100u && mode_r != ST_STARTUP) begin
        uv_latch_r <= 1'b1;
      end else if (sup.below_on_hys) begin
        uv_latch_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  assign trig = (period_cnt_r == 32'(COUNT_PERIOD - 1));

  // Free-running 50 ms trigger
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) period_cnt_r <= '0;
    else if (trig) period_cnt_r <= '0;
    else period_cnt_r <= period_cnt_r + 32'd1;
  end

  // Ringing suppression loads on turn-off, length picked by input level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ring_cnt_r <= '0;
    end else if (turn_off) begin
      ring_cnt_r <= cmp.zc_above_1v ? 16'(RING_SHORT_CYC) : 16'(RING_LONG_CYC);
    end else if (ring_cnt_r != 16'h0000) begin
      ring_cnt_r <= ring_cnt_r - 16'h0001;
    end
  end

  // Restart timer runs only while gate is low and input under 50 mV
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) rst_cnt_r <= '0;
    else if (gate_drive_r || cmp.zc_above_50m || restart) rst_cnt_r <= '0;
    else rst_cnt_r <= rst_cnt_r + 16'h0001;
  end
  assign restart = (rst_cnt_r == 16'(RESTART_CYC - 1));

  // ---------------------------------------------------------------
  // Zero crossings and skip counter
  // ---------------------------------------------------------------
  assign zc_fall = zc_prev_r && !cmp.zc_above_50m;

  // Crossing counter, cleared at each turn-off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      zc_prev_r   <= 1'b0;
      cross_cnt_r <= '0;
    end else begin
      zc_prev_r <= cmp.zc_above_50m;
      if (turn_off) cross_cnt_r <= '0;
      else if (zc_fall && cross_cnt_r != 4'hF) cross_cnt_r <= cross_cnt_r + 4'h1;
    end
  end

  // Range flags; a capture in the trigger cycle survives the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      up_flag_r <= 1'b0;
      dn_flag_r <= 1'b0;
    end else begin
      up_flag_r <= cmp.fb_below_3v5 | (up_flag_r & ~trig);
      dn_flag_r <= cmp.fb_above_4v4 | (dn_flag_r & ~trig);
    end
  end

  // Skip counter with immediate reload at heavy load
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      skip_count_r <= SKIP_RESET;
    end else if (cmp.fb_above_4v8) begin
      skip_count_r <= SKIP_RESET;
    end else if (trig) begin
      if (dn_flag_r && skip_count_r != SKIP_MIN) begin
        skip_count_r <= skip_count_r - 4'h1;
      end else if (up_flag_r && !dn_flag_r && skip_count_r != SKIP_MAX) begin
        skip_count_r <= skip_count_r + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Gate drive
  // ---------------------------------------------------------------
  assign gate_block = (mode_r == ST_STARTUP) || ovp_latch_r || fault_latch_r
                      || uv_latch_r || (burst_arm_r && cmp.fb_below_2v)
                      || burst_off_sel_r || cmp.zc_above_50m;
  assign turn_off   = gate_drive_r && (cmp.pcs_ge_fb || gate_block);
  // Valley match or restart, never inside suppression
  assign turn_on    = !gate_drive_r && !gate_block && ring_cnt_r == 16'h0000
                      && ((zc_fall && ({1'b0, cross_cnt_r} + 5'h01) >= {1'b0, skip_count_r})
                      || restart);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) gate_drive_r <= 1'b0;
    else if (turn_off) gate_drive_r <= 1'b0;
    else if (turn_on) gate_drive_r <= 1'b1;
  end

  // Primary regulation sink and charging resistor control
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fb_sink_en_r <= 1'b0;
      res_flag_r   <= 1'b0;
      fb_res_en_r  <= 1'b1;
    end else begin
      fb_sink_en_r <= cmp.zc_above_5v;
      if (cmp.zc_above_4v4) res_flag_r <= 1'b1;
      else if (turn_off) res_flag_r <= 1'b0;
      if (turn_off) fb_res_en_r <= 1'b1;
      else if (res_flag_r && !cmp.zc_above_50m) fb_res_en_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_off_on_limit;
    @(posedge sys_clk) disable iff (rst) (gate_drive_r && cmp.pcs_ge_fb) |=> !gate_drive_r;
  endproperty
  a_off_on_limit: assert property (p_off_on_limit) else $error("gate not cut at limit");

  property p_ring_block;
    @(posedge sys_clk) disable iff (rst) $fell(gate_drive_r) |-> !gate_drive_r [*8];
  endproperty
  a_ring_block: assert property (p_ring_block) else $error("turn-on inside ringing");

  property p_zc_low;
    @(posedge sys_clk) disable iff (rst) cmp.zc_above_50m |=> !gate_drive_r;
  endproperty
  a_zc_low: assert property (p_zc_low) else $error("gate high above 50 mV");

  property p_reload;
    @(posedge sys_clk) disable iff (rst) cmp.fb_above_4v8 |=> skip_count_r == 4'h1;
  endproperty
  a_reload: assert property (p_reload) else $error("skip not reloaded");

  property p_hold;
    @(posedge sys_clk) disable iff (rst) !trig && !cmp.fb_above_4v8 |=> $stable(skip_count_r);
  endproperty
  a_hold: assert property (p_hold) else $error("skip moved off trigger");

  property p_ovp;
    @(posedge sys_clk) disable iff (rst) sup.above_ovp |=> ovp_latch_r ##1 !gate_drive_r;
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage not latched");

  property p_fault;
    @(posedge sys_clk) disable iff (rst) cmp.fault_trip |=> fault_latch_r;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not latched");

  property p_res;
    @(posedge sys_clk) disable iff (rst) $fell(gate_drive_r) |-> fb_res_en_r;
  endproperty
  a_res: assert property (p_res) else $error("resistor not reconnected");

  property p_startup;
    @(posedge sys_clk) disable iff (rst) mode_r == ST_STARTUP |=> !gate_drive_r;
  endproperty
  a_startup: assert property (p_startup) else $error("gate high in start-up");

endmodule : quasiresonant_gate_sequencer

// *** sim/analog_front_model.sv ***
`timescale 1ns/1ps
module analog_front_model
  import qr_seq_pkg::*;
(
  // Levels set by the bench, in mV or uA
  input  wire logic [15:0] rzi_mv,
  input  wire logic [15:0] fb_mv,
  input  wire logic [15:0] vcc_mv,
  input  wire logic [15:0] pcs_ua,
  input  wire logic        pcs_hit,
  input  wire logic        fault_pin,
  // Gate as seen by the power switch
  input  wire logic        gate,
  // Comparator results
  output qr_seq_pkg::cmp_s cmp,
  output qr_seq_pkg::sup_s sup
);
  // ------------------------------------------------------------
  // Ideal comparators
  // ------------------------------------------------------------
  // No hysteresis, so each edge lands where the bench places it
  always_comb begin
    cmp.pcs_ge_fb      = pcs_hit;
    cmp.zc_above_50m   = rzi_mv > 16'h0032;
    cmp.zc_above_1v    = rzi_mv > 16'h03E8;
    cmp.zc_above_4v4   = rzi_mv > 16'h1130;
    cmp.zc_above_5v    = rzi_mv > 16'h1388;
    cmp.fb_below_2v    = fb_mv < 16'h07D0;
    cmp.fb_below_3v5   = fb_mv < 16'h0DAC;
    cmp.fb_above_4v4   = fb_mv > 16'h1130;
    cmp.fb_above_4v8   = fb_mv > 16'h12C0;
    cmp.pcs_below_100u = !gate && (pcs_ua < 16'h0064); // Sensed in off-time only
    cmp.fault_trip     = fault_pin;                    // Unused pin is grounded
    sup.above_on       = vcc_mv >= 16'h3A98;
    sup.below_off_norm = vcc_mv < 16'h2328;
    sup.below_off_burst = vcc_mv < 16'h38A4;
    sup.above_ovp      = vcc_mv > 16'h4E20;
    sup.below_on_hys   = vcc_mv < 16'h3908;
  end
endmodule : analog_front_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import qr_seq_pkg::*;
  // ------------------------------------------------------------
  // Stimulus levels and design ports
  // ------------------------------------------------------------
  localparam int CNT_P = 200;
  localparam logic [15:0] ZC_100 = 16'h0064, ZC_500 = 16'h01F4, ZC_2V = 16'h07D0,
    ZC_4V8 = 16'h12C0, ZC_5V5 = 16'h157C, FB_1V5 = 16'h05DC, FB_3V = 16'h0BB8,
    FB_4V = 16'h0FA0, FB_4V6 = 16'h11F8, FB_4V9 = 16'h1324, VCC_RUN = 16'h3A98,
    VCC_LOW = 16'h36B0, VCC_HYS = 16'h38D6, VCC_OVP = 16'h5014;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] rzi_mv = ZC_100;
  logic [15:0] fb_mv = FB_4V;
  logic [15:0] vcc_mv = 16'h0000;
  logic [15:0] pcs_ua = 16'h00C8;
  logic        pcs_hit = 1'b0;
  logic        fault_pin = 1'b0;
  cmp_s        cmp;
  sup_s        sup;
  logic        gate, fb_sink, fb_res, soft_sink, ref_en, burst_sel, ovp, fault, uv;
  logic [3:0]  skip;
  int          num_errors = 0;
  int          check_count = 0;

  always #2 sys_clk = ~sys_clk;

  analog_front_model analog_front_model_i (.rzi_mv(rzi_mv), .fb_mv(fb_mv), .vcc_mv(vcc_mv),
    .pcs_ua(pcs_ua), .pcs_hit(pcs_hit), .fault_pin(fault_pin), .gate(gate), .cmp(cmp),
    .sup(sup));
  quasiresonant_gate_sequencer #(.COUNT_PERIOD(CNT_P), .SOFT_PERIOD(5000))
    quasiresonant_gate_sequencer_i (.sys_clk(sys_clk), .rst(rst), .cmp(cmp), .sup(sup),
    .gate_drive_r(gate), .fb_sink_en_r(fb_sink), .fb_res_en_r(fb_res),
    .soft_sink_en_r(soft_sink), .ref_en_r(ref_en), .burst_off_sel_r(burst_sel),
    .skip_count_r(skip), .ovp_latch_r(ovp), .fault_latch_r(fault), .uv_latch_r(uv));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Inputs only move on falling edges, away from sampling
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  function automatic logic pick(input int sel);
    case (sel)
      0: return gate;
      1: return ovp;
      2: return fault;
      default: return uv;
    endcase
  endfunction : pick

  // Bounded wait on the gate; a spent limit ends the run
  task automatic wait_gate(input logic v, input int lim, output int n);
    n = 0;
    while (gate !== v && n < lim) begin
      tick(1);
      n++;
    end
    if (gate !== v) begin
      check(4'(gate), 4'(v));
      close_out();
    end
  endtask : wait_gate

  // Waits one trigger for the skip count to move, then compares
  task automatic step_skip(input logic [3:0] exp);
    logic [3:0] last;
    int         n;
    last = skip;
    n = 0;
    while (skip === last && n < CNT_P + 20) begin
      tick(1);
      n++;
    end
    check(skip, exp);
    // A trigger that never came ends the run
    if (skip === last) close_out();
  endtask : step_skip

  task automatic load_one();
    fb_mv = FB_4V9;
    tick(3);
    check(skip, 4'h1);
    fb_mv = FB_4V;
    step_skip(4'h0);
  endtask : load_one

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    int n;
    int i;
    tick(12);
    rst = 1'b0;
    check(4'(gate), 4'h0);
    check(4'(ref_en), 4'h0);
    check(skip, 4'h1);
    vcc_mv = VCC_RUN;
    fb_mv = FB_1V5;
    tick(3);
    check(4'(ref_en), 4'h1);
    check(4'(soft_sink), 4'h1);
    tick(2000);
    check(4'(burst_sel), 4'h0);
    load_one();
    $display("test power_up done");
    fb_mv = FB_3V;
    for (i = 1; i <= 15; i++) step_skip(4'(i));
    tick(CNT_P + 20);
    check(skip, 4'hF);
    fb_mv = FB_4V;
    tick(2 * CNT_P + 50);
    check(skip, 4'hF);
    fb_mv = FB_4V6;
    step_skip(4'hE);
    step_skip(4'hD);
    fb_mv = FB_4V;
    step_skip(4'hC);
    fb_mv = FB_3V;
    tick(3);
    fb_mv = FB_4V;
    step_skip(4'hD);
    tick(2 * CNT_P + 50);
    check(skip, 4'hD);
    load_one();
    check(4'(soft_sink), 4'h0);
    check(4'(gate), 4'h0);
    $display("test skip_counter done");
    rzi_mv = 16'h0000;
    wait_gate(1'b1, 4, n);
    pcs_hit = 1'b1;
    tick(2);
    check(4'(gate), 4'h0);
    check(4'(fb_res), 4'h1);
    pcs_hit = 1'b0;
    wait_gate(1'b1, 13000, n);
    check(4'(n > 7400), 4'h1);
    for (i = 0; i < 2; i++) begin
      rzi_mv = i ? ZC_500 : ZC_2V;
      pcs_hit = 1'b1;
      tick(2);
      pcs_hit = 1'b0;
      check(4'(gate), 4'h0);
      tick(i ? 1000 : 100);
      rzi_mv = 16'h0000;
      tick(3);
      check(4'(gate), 4'h0);
      tick(i ? 6700 : 700);
      rzi_mv = ZC_500;
      tick(2);
      rzi_mv = 16'h0000;
      wait_gate(1'b1, 4, n);
    end
    // Skip of two: first crossing ignored, second turns the gate on
    fb_mv = FB_3V;
    step_skip(4'h1);
    fb_mv = FB_4V;
    step_skip(4'h2);
    rzi_mv = ZC_2V;
    pcs_hit = 1'b1;
    tick(2);
    pcs_hit = 1'b0;
    tick(800);
    rzi_mv = 16'h0000;
    tick(3);
    check(4'(gate), 4'h0);
    rzi_mv = ZC_500;
    tick(2);
    rzi_mv = 16'h0000;
    wait_gate(1'b1, 4, n);
    $display("test gate_timing done");
    rzi_mv = ZC_5V5;
    tick(3);
    check(4'(fb_sink), 4'h1);
    check(4'(gate), 4'h0);
    rzi_mv = ZC_4V8;
    tick(3);
    check(4'(fb_sink), 4'h0);
    rzi_mv = 16'h0000;
    tick(3);
    check(4'(fb_res), 4'h0);
    wait_gate(1'b1, 13000, n);
    // Burst entry cuts a running gate, which also reconnects the resistor
    fb_mv = FB_1V5;
    tick(3);
    check(4'(fb_res), 4'h1);
    $display("test regulation done");
    check(4'(gate), 4'h0);
    check(4'(burst_sel), 4'h1);
    vcc_mv = VCC_LOW;
    tick(3);
    check(4'(ref_en), 4'h0);
    fb_mv = FB_4V;
    vcc_mv = VCC_RUN;
    tick(3);
    check(4'(ref_en), 4'h1);
    check(4'(burst_sel), 4'h0);
    $display("test burst done");
    for (i = 1; i < 4; i++) begin
      vcc_mv = (i == 1) ? VCC_OVP : VCC_RUN;
      fault_pin = (i == 2);
      pcs_ua = (i == 3) ? 16'h0032 : 16'h00C8;
      tick(3);
      check(4'(pick(i)), 4'h1);
      check(4'(gate), 4'h0);
      vcc_mv = VCC_RUN;
      fault_pin = 1'b0;
      pcs_ua = 16'h00C8;
      tick(3);
      check(4'(pick(i)), 4'h1);
      vcc_mv = VCC_HYS;
      tick(3);
      check(4'(pick(i)), 4'h0);
      vcc_mv = VCC_RUN;
    end
    $display("test latches done");
    close_out();
  end
endmodule : testbench
